// >>> common/rpm_consts.vh
// Purpose: constants for the reset pin manager
// Assumes: 32-bit AXI4-Lite register access, byte addresses
// Notes: offsets are word aligned
`ifndef RPM_CONSTS_VH
`define RPM_CONSTS_VH

// Register byte offsets
`define RPM_OFF_CTRL      4'h0
`define RPM_OFF_MODE      4'h4
`define RPM_OFF_STATUS    4'h8
`define RPM_OFF_IRQ_MASK  4'hC

// Control register bits (write one to act)
`define RPM_CTRL_PROC     0
`define RPM_CTRL_PERIPH   2
`define RPM_CTRL_EXT      3

// Mode register fields
`define RPM_MODE_RST_EN   0
`define RPM_MODE_IRQ_EN   4
`define RPM_MODE_LEN_LO   8
`define RPM_MODE_LEN_HI   11
`define RPM_MODE_RESET    32'h0000_0001

// Status register fields
`define RPM_ST_SEEN       0
`define RPM_ST_TYPE_LO    8
`define RPM_ST_TYPE_HI    10
`define RPM_ST_LEVEL      16
`define RPM_ST_SWBUSY     17

// Last reset type codes
`define RPM_TYPE_POWERUP  3'h0
`define RPM_TYPE_SOFT     3'h3
`define RPM_TYPE_USER     3'h4

// Timing in slow clock cycles
`define RPM_SYNC_STAGES   2
`define RPM_STARTUP_CYC   3'h3
`define RPM_SOFT_CYC      3'h3

// AXI responses
`define RPM_RESP_OKAY     2'h0
`define RPM_RESP_SLVERR   2'h2

`endif

// >>> src/rpm_sync.v
// Purpose: two flip-flop synchroniser for the reset pin input
// Assumes: input may be asynchronous to clk
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
module rpm_sync
(
	input  wire clk,
	input  wire arst_n,
	input  wire din,
	output wire dout
);
	reg meta_ff;
	reg sync_ff;

	// Two stages, idle level high (pin released)
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			meta_ff <= 1'b1;
			sync_ff <= 1'b1;
		end
		else
		begin
			meta_ff <= din;
			sync_ff <= meta_ff;
		end
	end

	assign dout = sync_ff;
endmodule

// >>> src/rpm_pulse.v
// Purpose: shapes the external reset pin pulse
// Assumes: start is a one-cycle pulse
// Notes: pulse lasts 2^(len+1) cycles
`timescale 1ns/1ps
module rpm_pulse
#(
	parameter LEN_W = 4
)
(
	input  wire             clk,
	input  wire             arst_n,
	input  wire             start,
	input  wire [LEN_W-1:0] len,
	output wire             busy
)
;
	localparam CNT_W = (1 << LEN_W) + 1;

	reg  [CNT_W-1:0] cnt_ff;
	wire [CNT_W-1:0] nxt_cnt;
	wire [CNT_W-1:0] one = {{(CNT_W-1){1'b0}}, 1'b1};

	// Load 2^(len+1) on start, then count down to zero
	// Shift amount one bit wider than len, so the top length does not wrap to zero
	assign nxt_cnt = start ? (one << ({1'b0, len} + {{LEN_W{1'b0}}, 1'b1})) :
		(cnt_ff != {CNT_W{1'b0}}) ? (cnt_ff - one) : cnt_ff;

	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			cnt_ff <= {CNT_W{1'b0}};
		else
			cnt_ff <= nxt_cnt;
	end

	assign busy = (cnt_ff != {CNT_W{1'b0}});
endmodule

// >>> src/rpm_top.v
// Purpose: reset pin manager and reset state manager front end
// Assumes: clk is the slow clock; AXI4-Lite slave for registers
// Notes: pin is open drain, driven low only
// Contract
// - Runs on slow clock; drives processor, peripheral and pin reset outputs.
// - Processor reset also resets the watchdog timer.
// - Peripheral reset resets every embedded peripheral.
// - Pin, peripheral and processor resets assertable alone or combined.
// - Resets asserted on external events and software commands.
// - Last reset source is recorded for software to read.
// - State manager requests pin assertion; pin manager drives it low.
// - Pin sampled on slow clock; low level reports a user reset.
// - Pin reset enable at 0 stops a low pin causing user reset.
// - Pin level readable anytime in status register.
// - Sticky pin-seen bit set on assertion, cleared by status read.
// - Pin interrupt enable at 1 raises interrupt instead of reset.
// - Pin held low for length set by pulse-length field.
// - Pulse lasts 2^(length+1) cycles; zero gives two cycles.
// - Leave user reset after two sync cycles plus three startup.
// - Processor reset release after user reset loads user type code.
// - Pin still held low externally keeps internal resets asserted.
`timescale 1ns/1ps
`include "rpm_consts.vh"
module rpm_top
#(
	parameter LEN_W = 4
)
(
	input  wire        clk,
	input  wire        arst_n,
	input  wire [3:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output wire [1:0]  s_axi_bresp,
	output wire        s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [3:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0]  s_axi_rresp,
	output wire        s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        pin_rst_i,
	output wire        pin_rst_o,
	output wire        pin_rst_oe,
	output wire        proc_rst_n,
	output wire        periph_rst_n,
	output wire        irq
);
	localparam ST_IDLE = 2'h0;
	localparam ST_USER = 2'h1;
	localparam ST_SOFT = 2'h2;
	localparam ST_WAIT = 2'h3;

	// Register decode used by both channels
	function [1:0] reg_sel;
		input [3:0] a;
		begin
			case (a)
				`RPM_OFF_CTRL:     reg_sel = 2'h0;
				`RPM_OFF_MODE:     reg_sel = 2'h1;
				`RPM_OFF_STATUS:   reg_sel = 2'h2;
				default:           reg_sel = 2'h3;
			endcase
		end
	endfunction

	reg  [31:0] mode_ff;
	reg  [31:0] mask_ff;
	reg         seen_ff;
	reg  [2:0]  type_ff;
	reg  [1:0]  st_ff;
	reg  [2:0]  cnt_ff;
	reg         sw_proc_ff;
	reg         sw_per_ff;
	reg         proc_ff;
	reg         per_ff;
	reg         pin_d_ff;
	reg  [1:0]  own_ff;
	reg         aw_ff;
	reg         w_ff;
	reg  [3:0]  awaddr_ff;
	reg  [31:0] wdata_ff;
	reg  [3:0]  wstrb_ff;
	reg         bvalid_ff;
	reg  [1:0]  bresp_ff;
	reg         rvalid_ff;
	reg  [31:0] rdata_ff;
	reg  [1:0]  rresp_ff;
	reg  [1:0]  nxt_st;
	reg  [2:0]  nxt_cnt;
	wire        pin_sync;
	wire        pulse_busy;
	wire        own_drv;
	wire        wr_go;
	wire        rd_go;
	wire        stat_rd;
	wire        pin_fall;
	wire        user_trig;
	wire        ext_req;
	wire        ctrl_wr;
	wire [31:0] status;
	wire [LEN_W-1:0] pulse_len;

	// Synchronise the pin before any detection
	rpm_sync u_sync
	(
		.clk    (clk),
		.arst_n (arst_n),
		.din    (pin_rst_i),
		.dout   (pin_sync)
	);

	assign pulse_len = mode_ff[`RPM_MODE_LEN_HI:`RPM_MODE_LEN_LO];

	// Pin pulse shaper
	rpm_pulse #(.LEN_W(LEN_W)) u_pulse
	(
		.clk    (clk),
		.arst_n (arst_n),
		.start  (ext_req),
		.len    (pulse_len),
		.busy   (pulse_busy)
	);

	// Open drain: drive low while the pulse runs
	assign pin_rst_o  = 1'b0;
	assign pin_rst_oe = pulse_busy;

	// AXI handshakes
	assign s_axi_awready = !aw_ff && !bvalid_ff;
	assign s_axi_wready  = !w_ff && !bvalid_ff;
	assign s_axi_arready = !rvalid_ff;
	assign wr_go   = aw_ff && w_ff && !bvalid_ff;
	assign rd_go   = s_axi_arvalid && !rvalid_ff;
	assign stat_rd = rd_go && (reg_sel(s_axi_araddr) == 2'h2);
	assign ctrl_wr = wr_go && (reg_sel(awaddr_ff) == 2'h0) && wstrb_ff[0];

	// Own pulse still shows in the synchroniser for two cycles after it ends
	assign own_drv = pulse_busy || (|own_ff);

	// Pin falling edge while not self-driven, in any state; user trigger on a low pin only from ST_IDLE
	assign pin_fall  = pin_d_ff && !pin_sync && !own_drv;
	assign user_trig = !pin_sync && !own_drv && mode_ff[`RPM_MODE_RST_EN]
		&& !mode_ff[`RPM_MODE_IRQ_EN] && (st_ff == ST_IDLE);

	// Software external pin request (ignored unless the state manager is in ST_IDLE)
	assign ext_req = ctrl_wr && (st_ff == ST_IDLE) && wdata_ff[`RPM_CTRL_EXT];

	assign status = {14'h0, (st_ff == ST_SOFT), pin_sync, 5'h0, type_ff, 7'h0, seen_ff};

	assign irq = |(status & mask_ff) || (seen_ff && mode_ff[`RPM_MODE_IRQ_EN]);

	// Reset state manager next state
	always @*
	begin
		nxt_st  = st_ff;
		nxt_cnt = cnt_ff;
		case (st_ff)
			ST_IDLE:
			begin
				if (user_trig)
					nxt_st = ST_USER;
				else if (ctrl_wr && (wdata_ff[`RPM_CTRL_PROC] || wdata_ff[`RPM_CTRL_PERIPH]
					|| wdata_ff[`RPM_CTRL_EXT]))
				begin
					nxt_st  = ST_SOFT;
					nxt_cnt = `RPM_SOFT_CYC;
				end
			end
			ST_USER:
			begin
				// Wait for the pin to rise past the synchroniser
				if (pin_sync && !pulse_busy)
				begin
					nxt_st  = ST_WAIT;
					nxt_cnt = `RPM_STARTUP_CYC;
				end
			end
			ST_WAIT:
			begin
				if (!pin_sync)
					nxt_st = ST_USER;
				else if (cnt_ff == 3'h1)
					nxt_st = ST_IDLE;
				else
					nxt_cnt = cnt_ff - 3'h1;
			end
			ST_SOFT:
			begin
				if (cnt_ff == 3'h1)
					nxt_st = ST_IDLE;
				else
					nxt_cnt = cnt_ff - 3'h1;
			end
			default:
				nxt_st = ST_IDLE;
		endcase
	end

	// State, reset lines and last reset type
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st_ff      <= ST_IDLE;
			cnt_ff     <= 3'h0;
			sw_proc_ff <= 1'b0;
			sw_per_ff  <= 1'b0;
			proc_ff    <= 1'b0;
			per_ff     <= 1'b0;
			type_ff    <= `RPM_TYPE_POWERUP;
			pin_d_ff   <= 1'b1;
			own_ff     <= 2'h0;
		end
		else
		begin
			st_ff    <= nxt_st;
			cnt_ff   <= nxt_cnt;
			pin_d_ff <= pin_sync;
			own_ff   <= {own_ff[0], pulse_busy};
			if (st_ff == ST_IDLE && nxt_st == ST_SOFT)
			begin
				sw_proc_ff <= wdata_ff[`RPM_CTRL_PROC];
				sw_per_ff  <= wdata_ff[`RPM_CTRL_PERIPH];
			end
			// Lines asserted (high) while in reset
			proc_ff <= (nxt_st == ST_USER) || (nxt_st == ST_WAIT)
				|| ((nxt_st == ST_SOFT) && ((st_ff == ST_SOFT) ? sw_proc_ff
				: wdata_ff[`RPM_CTRL_PROC]));
			per_ff  <= (nxt_st == ST_USER) || (nxt_st == ST_WAIT)
				|| ((nxt_st == ST_SOFT) && ((st_ff == ST_SOFT) ? sw_per_ff
				: wdata_ff[`RPM_CTRL_PERIPH]));
			// Type loaded when processor reset releases
			if (st_ff == ST_WAIT && nxt_st == ST_IDLE)
				type_ff <= `RPM_TYPE_USER;
			else if (st_ff == ST_SOFT && nxt_st == ST_IDLE && sw_proc_ff)
				type_ff <= `RPM_TYPE_SOFT;
		end
	end

	assign proc_rst_n   = !proc_ff;
	assign periph_rst_n = !per_ff;

	// Sticky pin-seen bit; set wins over read clear
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			seen_ff <= 1'b0;
		else if (pin_fall)
			seen_ff <= 1'b1;
		else if (stat_rd)
			seen_ff <= 1'b0;
	end

	// Write channel capture and register writes
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			aw_ff     <= 1'b0;
			w_ff      <= 1'b0;
			awaddr_ff <= 4'h0;
			wdata_ff  <= 32'h0;
			wstrb_ff  <= 4'h0;
			bvalid_ff <= 1'b0;
			bresp_ff  <= `RPM_RESP_OKAY;
			mode_ff   <= `RPM_MODE_RESET;
			mask_ff   <= 32'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_ff     <= 1'b1;
				awaddr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_ff     <= 1'b1;
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end
			if (wr_go)
			begin
				aw_ff     <= 1'b0;
				w_ff      <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff  <= `RPM_RESP_OKAY;
				case (awaddr_ff)
					`RPM_OFF_CTRL:
						bresp_ff <= `RPM_RESP_OKAY;
					`RPM_OFF_MODE:
					begin
						if (wstrb_ff[0])
							mode_ff[7:0] <= s_axi_wdata_mask(wdata_ff[7:0]);
						if (wstrb_ff[1])
							mode_ff[15:8] <= {4'h0, wdata_ff[11:8]};
					end
					`RPM_OFF_IRQ_MASK:
						if (wstrb_ff[0])
							mask_ff <= {31'h0, wdata_ff[0]};
					`RPM_OFF_STATUS:
						bresp_ff <= `RPM_RESP_SLVERR;
					default:
						bresp_ff <= `RPM_RESP_SLVERR;
				endcase
			end
			else if (bvalid_ff && s_axi_bready)
				bvalid_ff <= 1'b0;
		end
	end

	// Keep only the mode enable bits
	function [7:0] s_axi_wdata_mask;
		input [7:0] d;
		begin
			s_axi_wdata_mask = d & 8'h11;
		end
	endfunction

	// Read channel
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h0;
			rresp_ff  <= `RPM_RESP_OKAY;
		end
		else if (rd_go)
		begin
			rvalid_ff <= 1'b1;
			rresp_ff  <= `RPM_RESP_OKAY;
			case (s_axi_araddr)
				`RPM_OFF_CTRL:     rdata_ff <= 32'h0;
				`RPM_OFF_MODE:     rdata_ff <= mode_ff;
				`RPM_OFF_STATUS:   rdata_ff <= status;
				`RPM_OFF_IRQ_MASK: rdata_ff <= mask_ff;
				default:
				begin
					rdata_ff <= 32'h0;
					rresp_ff <= `RPM_RESP_SLVERR;
				end
			endcase
		end
		else if (rvalid_ff && s_axi_rready)
			rvalid_ff <= 1'b0;
	end

	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp  = bresp_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata  = rdata_ff;
	assign s_axi_rresp  = rresp_ff;
endmodule

// >>> verif/rpm_board.sv
// Purpose: board devices sharing the reset line
// Assumes: the line has a pull-up
// Notes: press pulls the line low like a button
`timescale 1ns/1ps
module rpm_board
(
	input  wire dev_o,
	input  wire dev_oe,
	input  wire press,
	output wire line
);
	// Wired-AND of device and board; a released line floats high
	assign line = !(press || (dev_oe && !dev_o));
endmodule

// >>> verif/rpm_chk_asserts.sv
// Purpose: port checker for rpm_top
// Assumes: one clock, async active-low reset
// Notes: bound from the testbench
`timescale 1ns/1ps
module rpm_chk
(
	input wire        clk,
	input wire        arst_n,
	input wire        pin_rst_i,
	input wire        pin_rst_o,
	input wire        pin_rst_oe,
	input wire        proc_rst_n,
	input wire        periph_rst_n,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire [31:0] s_axi_rdata
);
	reg [16:0] oe_cnt_ff;
	// Length of the pulse now on the pin
	always @(posedge clk or negedge arst_n)
		if (!arst_n)
			oe_cnt_ff <= 17'h0;
		else
			oe_cnt_ff <= pin_rst_oe ? oe_cnt_ff + 17'h1 : 17'h0;
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	property p_low; pin_rst_oe |-> !pin_rst_o; endproperty
	a_low: assert property (p_low) else $error("pin driven high");
	property p_min; $rose(pin_rst_oe) |-> pin_rst_oe [*2]; endproperty
	a_min: assert property (p_min) else $error("pulse too short");
	property p_max; oe_cnt_ff <= 17'h10000; endproperty
	a_max: assert property (p_max) else $error("pulse too long");
	property p_sync; $fell(pin_rst_i) && !pin_rst_oe && proc_rst_n |=> proc_rst_n; endproperty
	a_sync: assert property (p_sync) else $error("pin not synchronised");
	property p_hold; !pin_rst_i && !pin_rst_oe && !proc_rst_n |=> !proc_rst_n && !periph_rst_n;
	endproperty
	a_hold: assert property (p_hold) else $error("reset left while pin low");
	property p_exit; $rose(pin_rst_i) && !$fell(pin_rst_oe) && !proc_rst_n
		|-> !proc_rst_n [*4] ##[1:4] proc_rst_n; endproperty
	a_exit: assert property (p_exit) else $error("user reset exit timing");
	property p_pair; $fell(proc_rst_n) && !pin_rst_i && !pin_rst_oe |-> !periph_rst_n; endproperty
	a_pair: assert property (p_pair) else $error("peripheral reset missing");
	property p_b; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
	a_b: assert property (p_b) else $error("write response dropped");
	property p_r; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_r: assert property (p_r) else $error("read data dropped");
endmodule

// >>> verif/testbench.sv
// Purpose: self-checking bench for rpm_top
// Assumes: 20 MHz slow clock, board model on the pin
// Notes: random lengths from a bench LFSR seeded at 25
`timescale 1ns/1ps
module testbench;
	localparam [27:0] ctl_tbl = 28'hDC95841;
	reg         clk, arst_n, press, clr;
	reg         s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	reg  [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb, c, ln;
	reg  [31:0] s_axi_wdata, q, v;
	reg  [15:0] rnd;
	reg  [17:0] run, plen;
	reg  [2:0]  hit, typ;
	reg  [1:0]  r;
	integer     num_errors, compares, i;
	wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire        pin_rst_i, pin_rst_o, pin_rst_oe, proc_rst_n, periph_rst_n, irq;
	wire [1:0]  s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	rpm_top dut_u (.*);
	rpm_board board_u (.dev_o(pin_rst_o), .dev_oe(pin_rst_oe),
		.press(press), .line(pin_rst_i));
	function [15:0] lfsr(input [15:0] s);
		lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function [17:0] pulse(input [3:0] l);
		pulse = 18'h1 << (l + 1);
	endfunction
	task chk(input string nm, input [31:0] seen, input [31:0] exp);
		begin
			compares = compares + 1;
			if (seen !== exp)
			begin
				num_errors = num_errors + 1;
				$display("unexpected %s: expected %h seen %h", nm, exp, seen);
			end
		end
	endtask
	task wrap_up;
		begin
			$display("checks %0d errors %0d", compares, num_errors);
			if (num_errors == 0 && compares > 0)
				$display("*** PASS ***");
			else
				$display("*** FAIL ***");
			$finish;
		end
	endtask
	task tmo(input ok);
		if (!ok)
		begin
			num_errors = num_errors + 1;
			wrap_up;
		end
	endtask
	// One AXI4-Lite write or read with a random ready delay
	task bus(input w, input [3:0] a, input [31:0] d);
		integer n;
		reg dn;
		begin
			@(posedge clk);
			rnd = lfsr(rnd);
			dn = 1'b0;
			s_axi_awaddr <= a;
			s_axi_araddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= w;
			s_axi_wvalid <= w;
			s_axi_arvalid <= !w;
			for (n = 0; n < 64 && !dn; n = n + 1)
			begin
				@(posedge clk);
				if (s_axi_awready) s_axi_awvalid <= 1'b0;
				if (s_axi_wready) s_axi_wvalid <= 1'b0;
				if (s_axi_arready) s_axi_arvalid <= 1'b0;
				if (w ? s_axi_bvalid && s_axi_bready : s_axi_rvalid && s_axi_rready)
				begin
					dn = 1'b1;
					q = s_axi_rdata;
					r = w ? s_axi_bresp : s_axi_rresp;
					s_axi_bready <= 1'b0;
					s_axi_rready <= 1'b0;
				end
				else if (n >= rnd[1:0])
				begin
					s_axi_bready <= w;
					s_axi_rready <= !w;
				end
			end
			tmo(dn);
		end
	endtask
	task rdchk(input [3:0] a, input [31:0] m, input [31:0] e);
		begin
			bus(1'b0, a, 32'h0);
			chk("read", q & m, e);
		end
	endtask
	// Wait for the pulse record (0) or processor reset entry and release (1)
	task waitv(input s);
		integer n;
		reg     lo;
		begin
			lo = !s;
			for (n = 0; n < 4000 && !(lo && (s ? proc_rst_n : plen != 0) === 1'b1); n = n + 1)
			begin
				if (proc_rst_n === 1'b0) lo = 1'b1;
				@(posedge clk);
			end
			tmo(n < 4000);
		end
	endtask
	task push(input integer n);
		begin
			press <= 1'b1;
			repeat (n) @(posedge clk);
			press <= 1'b0;
		end
	endtask
	task clear;
		begin
			clr <= 1'b1;
			@(posedge clk);
			clr <= 1'b0;
		end
	endtask
	task irqchk(input e);
		begin
			repeat (2) @(posedge clk);
			chk("irq", irq, e);
		end
	endtask
	// Pin pulse length and reset activity since the last clear
	always @(posedge clk)
	begin
		run <= pin_rst_oe ? run + 18'h1 : 18'h0;
		if (clr)
			plen <= 18'h0;
		else if (!pin_rst_oe && run != 18'h0)
			plen <= run;
		hit <= clr ? 3'h0 : hit | {pin_rst_oe, ~periph_rst_n, ~proc_rst_n};
	end
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Main sequence
	initial
	begin
		{arst_n, press, clr, s_axi_awvalid, s_axi_wvalid} = 5'h0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
		s_axi_wstrb = 4'hF;
		{run, num_errors, compares, typ} = 0;
		rnd = 16'h0019;
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		rdchk(4'h4, 32'hFFFF_FFFF, 32'h1);
		rdchk(4'h8, 32'h3_0701, 32'h1_0000);
		bus(1'b1, 4'h8, 32'h0);
		chk("resp", r, 2'h2);
		for (i = 0; i < 3; i = i + 1)
		begin
			v = {rnd, lfsr(rnd)};
			bus(1'b1, 4'h4, v);
			rdchk(4'h4, 32'hFFFF_FFFF, v & 32'hF11);
		end
		// Software commands alone and combined; pulse lengths include zero and a long one
		for (i = 0; i < 7; i = i + 1)
		begin
			c = ctl_tbl >> (4 * i);
			ln = (i == 2) ? 4'h0 : (i == 4) ? 4'hA : {2'h0, rnd[1:0]};
			bus(1'b1, 4'h4, {20'h0, ln, 8'h01});
			clear;
			bus(1'b1, 4'h0, {28'h0, c});
			repeat (6) @(posedge clk);
			if (c[3]) waitv(1'b0);
			if (c[0]) typ = 3'h3;
			rdchk(4'h8, 32'h2_0701, {21'h0, typ, 8'h0});
			chk("resets", hit, {c[3], c[2], c[0]});
			if (c[3]) chk("pulse", plen, pulse(ln));
		end
		// User reset from the board, the last press held long
		bus(1'b1, 4'h4, 32'h1);
		for (i = 0; i < 3; i = i + 1)
		begin
			clear;
			push(i == 2 ? 40 : 3 + rnd[3:0]);
			waitv(1'b1);
			chk("resets", hit, 3'h3);
			rdchk(4'h8, 32'h3_0701, 32'h1_0401);
			rdchk(4'h8, 32'h1, 32'h0);
		end
		// Interrupt instead of reset with the reset enable still on, then masking
		bus(1'b1, 4'h4, 32'h11);
		clear;
		push(4);
		irqchk(1'b1);
		chk("resets", hit, 3'h0);
		rdchk(4'h8, 32'h1, 32'h1);
		irqchk(1'b0);
		bus(1'b1, 4'h4, 32'h0);
		press <= 1'b1;
		repeat (4) @(posedge clk);
		rdchk(4'h8, 32'h1_0000, 32'h0);
		press <= 1'b0;
		repeat (3) @(posedge clk);
		push(4);
		irqchk(1'b0);
		chk("resets", hit, 3'h0);
		bus(1'b1, 4'hC, 32'h1);
		irqchk(1'b1);
		bus(1'b1, 4'hC, 32'h0);
		irqchk(1'b0);
		bus(1'b1, 4'hC, 32'h1);
		rdchk(4'h8, 32'h1, 32'h1);
		irqchk(1'b0);
		wrap_up;
	end
endmodule
bind rpm_top rpm_chk chk_u (.*);
